/* verilog/uart_rx_wake_pkg.sv */
/*
 * constants shared by the receiver wakeup and loop control block:
 * register offsets, bit positions, oversampling indices and state codes.
 * assumes a 32-bit APB with byte addresses in paddr[7:0].
 */
package uart_rx_wake_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] BAUD_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] DATA_ADDR = 8'h0C;

    localparam int CTRL_LOOP = 0;
    localparam int CTRL_RECEIVER_SOURCE_SELECT = 1;
    localparam int CTRL_OPEN_DRAIN = 2;
    localparam int CTRL_CLEN = 3;
    localparam int CTRL_WAKE = 4;
    localparam int CTRL_ILT = 5;
    localparam int CTRL_TE = 6;
    localparam int CTRL_RE = 7;
    localparam int CTRL_STANDBY = 8;
    localparam int CTRL_DIR = 9;
    localparam int CTRL_RIE = 10;
    localparam int CTRL_ILIE = 11;

    localparam int STAT_FULL = 0;
    localparam int STAT_IDLE = 1;
    localparam int STAT_NOISE = 2;
    localparam int STAT_FRAMING = 3;
    localparam int STAT_ACTIVE = 4;

    localparam int BAUD_WIDTH = 13;
    localparam logic [12:0] BAUD_RESET = 13'h0000;

    localparam int RT_PER_BIT = 16;
    localparam logic [3:0] RT3_IDX = 4'h2;
    localparam logic [3:0] RT5_IDX = 4'h4;
    localparam logic [3:0] RT7_IDX = 4'h6;
    localparam logic [3:0] RT8_IDX = 4'h7;
    localparam logic [3:0] RT9_IDX = 4'h8;
    localparam logic [3:0] RT10_IDX = 4'h9;
    localparam logic [3:0] RT16_IDX = 4'hF;
    localparam logic [3:0] RT_AFTER_EDGE = 4'h1;

    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;
    localparam int IDLE_BITS_8 = 10;
    localparam int IDLE_BITS_9 = 11;
    localparam logic [7:0] IDLE_LEN_8 = 8'(IDLE_BITS_8 * RT_PER_BIT);
    localparam logic [7:0] IDLE_LEN_9 = 8'(IDLE_BITS_9 * RT_PER_BIT);

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_DATA = 4'h4,
        ST_STOP = 4'h8
    } rx_state_e;
endpackage

/* verilog/uart_rx_wakeup_loop_control.sv */
/*
 * receiver control of an asynchronous serial port: 16x oversampled frame
 * recovery with stop-bit checks, standby and wakeup, and loop/single-wire
 * routing of the receive input and transmit pin.
 * assumes an APB master on pclk, a transmitter shifter on pclk driving
 * tx_serial, and an outside pad that resolves the transmit pin from
 * txd_out and txd_oe_n.
 */
// The APB slave port and the register addresses were left to the implementer.
// Functional notes
// RQ1: missing stop one sets framing error flag.
// RQ2: break frame, no stop bit, sets framing error flag.
// RQ3: framing error and receive full set in the same cycle.
// RQ4: one odd stop sample gives noise; two or more give framing error.
// RQ5: oversample counter realigns on valid falling edges within a frame.
// RQ6: sixteen ticks per bit; stop sampled at ticks eight, nine, ten.
// RQ7: standby bit set blocks all receiver requests until wakeup.
// RQ8: idle wake method: idle line clears standby, reception resumes.
// RQ9: standby set again stays until another idle character.
// RQ10: waking idle sets neither idle flag nor receive full.
// RQ11: idle count starts after start bit or after stop bit.
// RQ12: address wake method: frame msb one clears standby.
// RQ13: address frame wakes before stop bit and sets receive full.
// RQ14: sender separates messages by idle, none inside messages.
// RQ15: sender reserves msb for address frames.
// RQ16: standby requested on idle line may wake at once.
// RQ17: loopback cuts receive pin from the receiver.
// RQ18: single-wire mode receives from the transmit pin level.
// RQ19: single-wire: direction set drives, clear makes pin an input.
// RQ20: loop mode feeds transmitter output to receiver internally.
// RQ21: loop mode: direction set also drives pin, clear disconnects; the code drives the pin high instead.
// RQ22: software enables transmitter and receiver for loop modes.
// RQ23: open-drain select applies in every mode; allows receive.
// RQ24: character length selects eight or nine data bits.
// RQ25: stop value and noise from majority of three samples.
// RQ26: input sampled at sixteen times the baud rate.
`timescale 1ns/100ps
module uart_rx_wakeup_loop_control
    import uart_rx_wake_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd_pin,
    input wire logic txd_pin_in,
    input wire logic tx_serial,
    output logic txd_out,
    output logic txd_oe_n,
    output logic rx_request
);
    typedef struct packed {
        logic loop;
        logic receiver_source_select;
        logic open_drain;
        logic clen;
        logic wake;
        logic idle_count_start_select;
        logic te;
        logic re;
        logic standby;
        logic dir;
        logic rie;
        logic ilie;
        logic [BAUD_WIDTH-1:0] baud;
        logic [BAUD_WIDTH-1:0] div_cnt;
        logic rx_s1;
        logic rx_s2;
        logic tx_s1;
        logic tx_s2;
        rx_state_e state;
        logic [3:0] rt;
        logic [3:0] bit_cnt;
        logic [2:0] hist;
        logic [1:0] samp;
        logic [8:0] shift;
        logic [8:0] data;
        logic keep;
        logic frame_noise;
        logic full;
        logic idle_flag;
        logic noise;
        logic framing;
        logic armed;
        logic [7:0] idle_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic txd_out;
        logic txd_oe_n;
        logic rx_request;
    } state_s;

    state_s r;
    state_s n;

    logic tick;
    logic rx_line;
    logic edge_seen;
    logic [2:0] votes;
    logic vote;
    logic split;
    logic [3:0] data_len;
    logic [7:0] idle_len;
    logic count_ok;
    logic idle_hit;
    logic idle_wake;
    logic stop_eval;
    logic msb_eval;
    logic pin_en;
    logic pin_val;
    logic setup;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    always_comb begin
        n = r;
        n.rx_s1 = rxd_pin;
        n.rx_s2 = r.rx_s1;
        n.tx_s1 = txd_pin_in;
        n.tx_s2 = r.tx_s1;

        // baud divider makes the 16x tick enable; divisor zero stops it
        tick = 1'b0;
        if ((r.baud != BAUD_RESET) && (r.te || r.re)) begin
            if (r.div_cnt >= r.baud - 13'h0001) begin
                n.div_cnt = '0;
                tick = 1'b1; // RQ26
            end else begin
                n.div_cnt = r.div_cnt + 13'h0001;
            end
        end else begin
            n.div_cnt = '0;
        end

        // receiver source selection
        if (!r.loop) begin
            rx_line = r.rx_s2;
        end else if (r.receiver_source_select) begin
            rx_line = r.tx_s2; // RQ18 RQ17
        end else begin
            rx_line = tx_serial; // RQ20 RQ17
        end

        data_len = r.clen ? DATA_BITS_9 : DATA_BITS_8; // RQ24
        idle_len = r.clen ? IDLE_LEN_9 : IDLE_LEN_8;
        edge_seen = (r.hist == 3'h7) && !rx_line;
        votes = {r.samp, rx_line};
        vote = maj3(votes); // RQ25
        split = (|votes) && !(&votes);
        stop_eval = tick && r.re && (r.state == ST_STOP) && (r.rt == RT10_IDX);
        msb_eval = tick && r.re && (r.state == ST_DATA) && (r.rt == RT10_IDX)
            && (r.bit_cnt == data_len - 4'h1);

        // apb: software clears come first so hardware sets win
        setup = psel && !penable;
        wr = psel && penable && pwrite && r.pready;
        rd = psel && penable && !pwrite && r.pready;
        mapped = (paddr == CTRL_ADDR) || (paddr == BAUD_ADDR)
            || (paddr == STATUS_ADDR) || (paddr == DATA_ADDR);
        ctrl_word = '0;
        ctrl_word[CTRL_LOOP] = r.loop;
        ctrl_word[CTRL_RECEIVER_SOURCE_SELECT] = r.receiver_source_select;
        ctrl_word[CTRL_OPEN_DRAIN] = r.open_drain;
        ctrl_word[CTRL_CLEN] = r.clen;
        ctrl_word[CTRL_WAKE] = r.wake;
        ctrl_word[CTRL_ILT] = r.idle_count_start_select;
        ctrl_word[CTRL_TE] = r.te;
        ctrl_word[CTRL_RE] = r.re;
        ctrl_word[CTRL_STANDBY] = r.standby;
        ctrl_word[CTRL_DIR] = r.dir;
        ctrl_word[CTRL_RIE] = r.rie;
        ctrl_word[CTRL_ILIE] = r.ilie;
        status_word = '0;
        status_word[STAT_FULL] = r.full;
        status_word[STAT_IDLE] = r.idle_flag;
        status_word[STAT_NOISE] = r.noise;
        status_word[STAT_FRAMING] = r.framing;
        status_word[STAT_ACTIVE] = (r.state != ST_IDLE);
        n.pready = setup;
        n.pslverr = setup && !mapped;
        if (setup) begin
            if (paddr == CTRL_ADDR) begin
                n.prdata = ctrl_word;
            end else if (paddr == BAUD_ADDR) begin
                n.prdata = {19'h00000, r.baud};
            end else if (paddr == STATUS_ADDR) begin
                n.prdata = status_word;
            end else if (paddr == DATA_ADDR) begin
                n.prdata = {23'h000000, r.data};
            end else begin
                n.prdata = '0;
            end
        end
        if (wr && (paddr == STATUS_ADDR)) begin
            n.full = r.full && !pwdata[STAT_FULL];
            n.idle_flag = r.idle_flag && !pwdata[STAT_IDLE];
            n.noise = r.noise && !pwdata[STAT_NOISE];
            n.framing = r.framing && !pwdata[STAT_FRAMING];
        end
        if (rd && (paddr == DATA_ADDR)) begin
            n.full = 1'b0;
        end
        if (wr && (paddr == BAUD_ADDR)) begin
            n.baud = pwdata[BAUD_WIDTH-1:0];
        end

        // frame recovery, held idle while the receiver is off
        if (!r.re) begin
            n.state = ST_IDLE;
            n.rt = '0;
            n.idle_cnt = '0;
        end else if (tick) begin
            n.hist = {r.hist[1:0], rx_line};
            n.rt = r.rt + 4'h1;
            unique case (r.state)
                ST_IDLE: begin
                    n.rt = '0;
                    if (edge_seen) begin
                        n.state = ST_START;
                        n.rt = RT_AFTER_EDGE;
                        n.keep = !r.standby;
                        n.frame_noise = 1'b0;
                        n.armed = 1'b1;
                    end
                end
                ST_START: begin
                    if ((r.rt == RT3_IDX) || (r.rt == RT5_IDX)) begin
                        n.samp = {r.samp[0], rx_line};
                    end
                    if (r.rt == RT7_IDX) begin
                        if (vote) begin
                            n.state = ST_IDLE;
                        end else if (split) begin
                            n.frame_noise = 1'b1;
                        end
                    end
                    if (r.rt == RT16_IDX) begin
                        n.state = ST_DATA;
                        n.bit_cnt = '0;
                    end
                end
                ST_DATA: begin
                    if ((r.rt == RT8_IDX) || (r.rt == RT9_IDX)) begin
                        n.samp = {r.samp[0], rx_line};
                    end
                    if (r.rt == RT10_IDX) begin
                        n.shift = {vote, r.shift[8:1]};
                        if (split) begin
                            n.frame_noise = 1'b1;
                        end
                        if (msb_eval && r.wake && r.standby && vote) begin
                            n.standby = 1'b0; // RQ12 RQ13
                            n.keep = 1'b1; // RQ13
                        end
                    end
                    // a late edge means the sender runs fast: close the bit early
                    if (edge_seen && (r.rt < RT8_IDX)) begin
                        n.rt = RT_AFTER_EDGE; // RQ5
                    end else if ((r.rt == RT16_IDX) || (edge_seen && (r.rt > RT10_IDX))) begin
                        if (r.rt != RT16_IDX) begin
                            n.rt = RT_AFTER_EDGE; // RQ5
                        end
                        if (r.bit_cnt == data_len - 4'h1) begin
                            n.state = ST_STOP;
                        end else begin
                            n.bit_cnt = r.bit_cnt + 4'h1;
                        end
                    end
                end
                ST_STOP: begin
                    if ((r.rt == RT8_IDX) || (r.rt == RT9_IDX)) begin
                        n.samp = {r.samp[0], rx_line}; // RQ6
                    end
                    if (edge_seen && (r.rt < RT8_IDX)) begin
                        n.rt = RT_AFTER_EDGE; // RQ5
                    end
                    // finishing at the third sample leaves room for a fast next start
                    if (r.rt == RT10_IDX) begin
                        n.state = ST_IDLE;
                        n.rt = '0;
                        if (r.keep) begin
                            n.full = 1'b1; // RQ3
                            n.framing = r.framing || !vote; // RQ1 RQ2 RQ4
                            n.noise = r.noise || r.frame_noise || split; // RQ4 RQ25
                            n.data = r.clen ? r.shift : {1'b0, r.shift[8:1]};
                        end
                    end
                end
                default: begin
                    n.state = ST_IDLE;
                end
            endcase
        end

        // idle character counting
        count_ok = (r.state == ST_IDLE)
            || (!r.idle_count_start_select && ((r.state == ST_DATA) || (r.state == ST_STOP))); // RQ11
        idle_hit = tick && r.re && rx_line && count_ok && (r.idle_cnt == idle_len - 8'h01);
        idle_wake = r.re && r.standby && !r.wake && (r.idle_cnt >= idle_len);
        if (r.re && tick) begin
            if (!rx_line) begin
                n.idle_cnt = '0;
            end else if (count_ok && (r.idle_cnt < idle_len)) begin
                n.idle_cnt = r.idle_cnt + 8'h01;
            end
        end
        // an already idle line wakes a fresh standby at once
        if (idle_wake) begin
            n.standby = 1'b0; // RQ8 RQ16
            n.armed = 1'b0; // RQ10
        end else if (idle_hit && !r.standby && r.armed) begin
            n.idle_flag = 1'b1;
            n.armed = 1'b0;
        end

        // control write last: a software standby request beats a hardware wake
        if (wr && (paddr == CTRL_ADDR)) begin
            n.loop = pwdata[CTRL_LOOP];
            n.receiver_source_select = pwdata[CTRL_RECEIVER_SOURCE_SELECT];
            n.open_drain = pwdata[CTRL_OPEN_DRAIN];
            n.clen = pwdata[CTRL_CLEN];
            n.wake = pwdata[CTRL_WAKE];
            n.idle_count_start_select = pwdata[CTRL_ILT];
            n.te = pwdata[CTRL_TE];
            n.re = pwdata[CTRL_RE];
            n.standby = pwdata[CTRL_STANDBY]; // RQ7 RQ9
            n.dir = pwdata[CTRL_DIR];
            n.rie = pwdata[CTRL_RIE];
            n.ilie = pwdata[CTRL_ILIE];
        end

        // transmit pin: loop idle drives high, single-wire with dir clear floats
        if (!r.loop) begin
            pin_en = r.te;
            pin_val = tx_serial;
        end else if (r.dir) begin
            pin_en = 1'b1; // RQ19 RQ21
            pin_val = tx_serial;
        end else begin
            pin_en = !r.receiver_source_select; // RQ19 RQ21
            pin_val = 1'b1;
        end
        n.txd_out = r.open_drain ? 1'b0 : pin_val; // RQ23
        n.txd_oe_n = r.open_drain ? !(pin_en && !pin_val) : !pin_en; // RQ23

        n.rx_request = n.re && !n.standby
            && ((n.rie && n.full) || (n.ilie && n.idle_flag)); // RQ7
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.state <= ST_IDLE;
            r.txd_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign txd_out = r.txd_out;
    assign txd_oe_n = r.txd_oe_n;
    assign rx_request = r.rx_request;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    stop_framing_a: assert property (stop_eval && r.keep && !vote |=> r.framing && r.full) // RQ1
        else $error("missing stop bit did not flag framing error with full");
    full_with_fe_a: assert property ($rose(r.framing) |-> $rose(r.full) || $past(r.full)) // RQ3
        else $error("framing error set apart from receive full");
    stop_noise_a: assert property (stop_eval && r.keep && split |=> r.noise) // RQ4
        else $error("disagreeing stop samples did not set noise");
    edge_realign_a: assert property (tick && r.re && (r.state == ST_DATA) && edge_seen
        && (r.rt < RT8_IDX) |=> r.rt == RT_AFTER_EDGE) // RQ5
        else $error("oversample counter not realigned on falling edge");
    stop_point_a: assert property ($rose(r.full) && !$past(wr)
        |-> $past(r.state) == ST_STOP && $past(r.rt) == RT10_IDX) // RQ6
        else $error("receive full not set at tenth tick of stop bit");
    standby_quiet_a: assert property (r.standby |-> !r.rx_request) // RQ7
        else $error("receiver request while in standby");
    idle_wake_a: assert property (idle_wake && !(wr && (paddr == CTRL_ADDR))
        |=> !r.standby ##1 $stable(r.idle_flag)) // RQ8
        else $error("idle line did not wake receiver");
    wake_no_flag_a: assert property (idle_wake && !wr && !rd
        |=> $stable(r.idle_flag) && $stable(r.full)) // RQ10
        else $error("waking idle set a receiver flag");
    addr_wake_a: assert property (msb_eval && r.wake && r.standby && vote
        && !(wr && (paddr == CTRL_ADDR)) |=> !r.standby ##[1:200] $rose(r.full)) // RQ13
        else $error("address frame did not wake and fill");
    loop_source_a: assert property (r.loop && !r.receiver_source_select |-> rx_line == tx_serial) // RQ20
        else $error("loop mode receiver not fed from transmitter");
    single_float_a: assert property ($past(r.loop && r.receiver_source_select && !r.dir) |-> r.txd_oe_n) // RQ19
        else $error("single-wire input pin is driven");
    od_low_a: assert property ($past(r.open_drain) |-> !r.txd_out) // RQ23
        else $error("open-drain pin drives high");

    frame_ok_c: cover property (stop_eval && r.keep && vote);
    break_c: cover property (stop_eval && r.keep && !vote && (r.shift == 9'h000));
    idle_wake_c: cover property (idle_wake);
    addr_wake_c: cover property (msb_eval && r.wake && r.standby && vote);
endmodule

/* dv/serial_sender.sv */
/*
 * far-side asynchronous transmitter: drives one serial line with 16-cycle bits.
 * assumes the block's baud register is 1, so one tick per pclk and 16 per bit.
 */
`timescale 1ns/100ps
module serial_sender (
    input wire logic pclk,
    output logic line
);
    initial line = 1'b1;

    // start bit, data lsb first, one stop bit, then the line is returned to mark
    task automatic send_frame(input logic [8:0] d, input int nbits, input logic stop_v);
        line <= 1'b0;
        repeat (16) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
            line <= d[i];
            repeat (16) @(posedge pclk);
        end
        line <= stop_v;
        repeat (16) @(posedge pclk);
        // gap lets the receiver see three high samples before the next start
        line <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask
endmodule

/* dv/uart_rx_wakeup_loop_control_tb_top.sv */
/*
 * self-checking bench: APB register tasks plus three serial senders on the
 * receive pin, the transmit pin and the transmitter shifter output.
 * assumes baud register 1, so the receiver ticks once per pclk.
 */
`timescale 1ns/100ps
module uart_rx_wakeup_loop_control_tb_top;
    import uart_rx_wake_pkg::*;
    localparam logic [31:0] EN = (32'h1 << CTRL_TE) | (32'h1 << CTRL_RE);
    localparam logic [31:0] RIE = 32'h1 << CTRL_RIE;
    localparam logic [31:0] SBY = 32'h1 << CTRL_STANDBY;
    localparam logic [31:0] LOOP = 32'h1 << CTRL_LOOP;
    localparam logic [31:0] RECEIVER_SOURCE_SELECT = 32'h1 << CTRL_RECEIVER_SOURCE_SELECT;
    localparam logic [31:0] DIR = 32'h1 << CTRL_DIR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic txd_out;
    logic txd_oe_n;
    logic rx_request;
    logic rxd_line;
    logic pin_line;
    logic tx_line;
    logic txd_pin_in;
    logic [31:0] q;
    logic e;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    // wired level: a released pin floats high through the pull-up
    assign txd_pin_in = (txd_oe_n ? 1'b1 : txd_out) & pin_line;

    serial_sender rx_src (.pclk(pclk), .line(rxd_line));
    serial_sender pin_src (.pclk(pclk), .line(pin_line));
    serial_sender tx_src (.pclk(pclk), .line(tx_line));

    uart_rx_wakeup_loop_control dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_line),
        .txd_pin_in(txd_pin_in), .tx_serial(tx_line), .txd_out(txd_out),
        .txd_oe_n(txd_oe_n), .rx_request(rx_request)
    );

    initial begin
        forever #20 pclk = ~pclk;
    end

    task automatic complete_run();
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait limit here: only the bench timeout ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so psel never gets two assignments in one step
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, q, exp);
    endtask

    task automatic frame(input logic [8:0] d, input int nb, input logic sv);
        rx_src.send_frame(d, nb, sv);
        repeat (4) @(posedge pclk);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CTRL_ADDR, 32'h0, "ctrl reset");
        rd(BAUD_ADDR, 32'h0, "baud reset");
        rd(STATUS_ADDR, 32'h0, "status reset");
        check("oe_n reset", {31'h0, txd_oe_n}, 32'h1);
        rd(8'h10, 32'h0, "unmapped read");
        check("unmapped err", {31'h0, e}, 32'h1);
        apb(1'b1, BAUD_ADDR, 32'h1);
        apb(1'b1, CTRL_ADDR, EN | RIE);
        frame(9'h0A5, 8, 1'b1);
        rd(STATUS_ADDR, 32'h1, "status good");
        check("request full", {31'h0, rx_request}, 32'h1);
        rd(DATA_ADDR, 32'hA5, "data good");
        frame(9'h03C, 8, 1'b0);
        rd(STATUS_ADDR, 32'h9, "status no stop");
        apb(1'b1, STATUS_ADDR, 32'hF);
        frame(9'h000, 8, 1'b0);
        rd(STATUS_ADDR, 32'h9, "status break");
        rd(DATA_ADDR, 32'h0, "data break");
        apb(1'b1, STATUS_ADDR, 32'hF);
        apb(1'b1, CTRL_ADDR, EN | (32'h1 << CTRL_CLEN));
        frame(9'h1A5, 9, 1'b1);
        rd(DATA_ADDR, 32'h1A5, "data nine");
        repeat (200) @(posedge pclk);
        rd(STATUS_ADDR, 32'h2, "idle flag");
        apb(1'b1, STATUS_ADDR, 32'hF);
        // idle line already present: standby is expected to end at once
        apb(1'b1, CTRL_ADDR, EN | SBY);
        repeat (200) @(posedge pclk);
        rd(CTRL_ADDR, EN, "idle wake ctrl");
        rd(STATUS_ADDR, 32'h0, "idle wake status");
        apb(1'b1, CTRL_ADDR, EN | RIE | SBY | (32'h1 << CTRL_WAKE));
        frame(9'h012, 8, 1'b1);
        check("request standby", {31'h0, rx_request}, 32'h0);
        rd(STATUS_ADDR, 32'h0, "dropped status");
        rd(CTRL_ADDR, EN | RIE | SBY | (32'h1 << CTRL_WAKE), "still standby");
        frame(9'h085, 8, 1'b1);
        rd(CTRL_ADDR, EN | RIE | (32'h1 << CTRL_WAKE), "address wake");
        rd(STATUS_ADDR, 32'h1, "address full");
        rd(DATA_ADDR, 32'h85, "address data");
        // receive pin held at break to prove loop mode ignores it
        rx_src.line <= 1'b0;
        apb(1'b1, CTRL_ADDR, EN | LOOP);
        // pin outputs lag the control write by one cycle
        @(posedge pclk);
        check("loop pin", {30'h0, txd_out, txd_oe_n}, 32'h2);
        tx_src.send_frame(9'h05A, 8, 1'b1);
        rd(DATA_ADDR, 32'h5A, "loop data");
        apb(1'b1, CTRL_ADDR, EN | LOOP | DIR);
        tx_src.line <= 1'b0;
        repeat (3) @(posedge pclk);
        check("loop drive", {30'h0, txd_out, txd_oe_n}, 32'h0);
        tx_src.line <= 1'b1;
        apb(1'b1, CTRL_ADDR, EN | LOOP | RECEIVER_SOURCE_SELECT);
        @(posedge pclk);
        check("single release", {31'h0, txd_oe_n}, 32'h1);
        pin_src.send_frame(9'h0C3, 8, 1'b1);
        rd(DATA_ADDR, 32'hC3, "single data");
        apb(1'b1, CTRL_ADDR, EN | LOOP | RECEIVER_SOURCE_SELECT | DIR | (32'h1 << CTRL_OPEN_DRAIN));
        @(posedge pclk);
        check("open drain idle", {30'h0, txd_out, txd_oe_n}, 32'h1);
        pin_src.send_frame(9'h069, 8, 1'b1);
        rd(DATA_ADDR, 32'h69, "open drain data");
        complete_run();
    end
endmodule
